// ### bench/testbench.sv
// Self-checking bench for the T1 control block.
`timescale 1ns/100ps
`default_nettype none
`include "tsc_defines.svh"

module testbench import tsc_pkg::*; ;
	logic clock_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic oct_stb_i = 1'b0;
	logic [4:0] chan_i = 5'd0;
	logic [4:0] frame_i = 5'd1;
	logic esf_mode_i = 1'b1;
	logic line_bit_en_i = 1'b1;
	logic [7:0] serial_data_in_i = 8'h00;
	// Only the upper nibble holds a one, so the nibble choice shows.
	logic [7:0] sig_stream_in_i = 8'h80;
	logic rx_fdl_bit_i = 1'b0;
	logic rx_fdl_stb_i = 1'b0;
	logic [8:0] rx_oct = 9'h000;
	logic [7:0] reg_rdata_o, serial_data_out_o, sig_stream_out_o;
	logic [7:0] sig_stream_out_oe_o, tx_line_pos_o, tx_line_neg_o;
	logic [7:0] tx_slip_delay_o, data_pin;
	logic [15:0] tx_yellow_pattern_o;
	logic serial_data_out_oe_o, rx_yellow_det_o, tx_frame_bound_o;
	tsc_bipolar_t rails;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;

	// Short debounce tick keeps the run brief.
	tsc_t1_ctrl #(.NCH(24), .DB_TICK_CYCLES(200)) dut (
		.clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .oct_stb_i, .chan_i, .frame_i,
		.esf_mode_i, .line_bit_en_i, .serial_data_in_i,
		.sig_stream_in_i, .serial_data_out_o, .serial_data_out_oe_o,
		.sig_stream_out_o, .sig_stream_out_oe_o,
		.rx_line_pos_i(rails.pos), .rx_line_neg_i(rails.neg),
		.rx_fdl_bit_i, .rx_fdl_stb_i, .tx_line_pos_o, .tx_line_neg_o,
		.tx_yellow_pattern_o, .rx_yellow_det_o, .tx_slip_delay_o,
		.tx_frame_bound_o);
	tsc_line_model model (.clock_i, .arst_n_i, .oct_stb_i,
		.octet_i(rx_oct), .data_out_i(serial_data_out_o),
		.data_oe_i(serial_data_out_oe_o), .rails_o(rails),
		.data_pin_o(data_pin));

	// ==========================================================
	// Clock, timebase and timeout
	initial begin
		forever #12.5 clock_i = ~clock_i;
	end

	// A strobe every second cycle, 24 channels to a frame, 24 frames.
	always @(posedge clock_i) begin
		oct_stb_i <= arst_n_i && !oct_stb_i;
		if (oct_stb_i) begin
			chan_i <= (chan_i == 5'd23) ? 5'd0 : chan_i + 5'd1;
			if (chan_i == 5'd23)
				frame_i <= (frame_i == 5'd24) ? 5'd1 : frame_i + 5'd1;
		end
	end

	// A hang counts as a failure.
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			test_done;
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic test_done;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
			input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t: %s seen %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the taking edge.
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	// Returns just after the strobe edge of frame f (0 = any), channel c.
	task automatic wait_oct(input logic [4:0] f, input logic [4:0] c);
		do @(posedge clock_i);
		while (!(oct_stb_i && chan_i == c && (f == 5'd0 || frame_i == f)));
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [7:0] d;
		logic [7:0] ra [4] = '{`TSC_OFS_SIG_CFG, `TSC_OFS_CODE_LOOP,
			`TSC_OFS_TX_DELAY, 8'h33};
		check(tx_yellow_pattern_o, `TSC_YEL_STD, "yellow");
		for (int i = 0; i < 4; i++) begin
			reg_rd(ra[i], d);
			check(d, 8'h00, "reset read");
		end
		$display("t_reset done");
	endtask

	task automatic t_enables;
		logic [7:0] d;
		logic [7:0] v [4] = '{8'h80, 8'h40, 8'h48, 8'hc8};
		logic [7:0] e [4] = '{8'h00, 8'h0f, 8'hf0, 8'hf0};
		for (int i = 0; i < 4; i++) begin
			reg_wr(`TSC_OFS_SIG_CFG, v[i]);
			repeat (2) @(posedge clock_i);
			#1;
			check(serial_data_out_oe_o, v[i][7], "data oe");
			check(sig_stream_out_oe_o, e[i], "sig oe");
			reg_rd(`TSC_OFS_SIG_CFG, d);
			check(d, v[i], "readback");
		end
		$display("t_enables done");
	endtask

	task automatic t_yellow(input logic jp);
		reg_wr(`TSC_OFS_SIG_CFG, {7'h00, jp});
		for (int i = 0; i < 16; i++) begin
			@(posedge clock_i);
			rx_fdl_bit_i <= 1'b1;
			rx_fdl_stb_i <= 1'b1;
			@(posedge clock_i);
			rx_fdl_stb_i <= 1'b0;
		end
		repeat (2) @(posedge clock_i);
		#1;
		check(tx_yellow_pattern_o, jp ? `TSC_YEL_JAPAN : `TSC_YEL_STD,
			"yellow tx");
		check(rx_yellow_det_o, jp, "yellow det");
		$display("t_yellow done");
	endtask

	// Expects {line marks, backplane pin} at channel 2 of frame f.
	task automatic t_oct(input logic [7:0] s, c, d, input logic [8:0] rx,
			input logic [4:0] f, input logic [15:0] e);
		reg_wr(`TSC_OFS_SIG_CFG, s);
		reg_wr(`TSC_OFS_CODE_LOOP, c);
		serial_data_in_i <= d;
		rx_oct <= rx;
		wait_oct(5'd0, 5'd1);
		wait_oct(f, 5'd2);
		check({tx_line_pos_o | tx_line_neg_o, data_pin}, e, "octet");
		$display("t_oct done");
	endtask

	// Reported octet after one to two multiframes of ones on bit 8.
	task automatic t_sig(input logic esf, input logic [7:0] s,
			input logic [7:0] e);
		reg_wr(`TSC_OFS_SIG_CFG, s);
		reg_wr(`TSC_OFS_CODE_LOOP, 8'h00);
		esf_mode_i <= esf;
		rx_oct <= 9'h001;
		repeat (2) wait_oct(5'd1, 5'd2);
		check(sig_stream_out_o, e, "nibble");
		$display("t_sig done");
	endtask

	// A change seen 48 cycles after commit must wait for the third tick.
	task automatic t_deb;
		t_sig(1'b1, 8'h50, 8'h0f);
		@(posedge clock_i);
		rx_oct <= 9'h000;
		wait_oct(5'd1, 5'd2);
		check(sig_stream_out_o[3:0], 4'hf, "held");
		wait_oct(5'd16, 5'd2);
		check(sig_stream_out_o[3:0], 4'h0, "released");
		$display("t_deb done");
	endtask

	task automatic t_delay(input logic [7:0] d, input logic [7:0] e);
		int gap;
		logic [7:0] r;
		wait_oct(5'd0, 5'd5);
		reg_wr(`TSC_OFS_TX_DELAY, d);
		reg_rd(`TSC_OFS_STATUS, r);
		check(r[1], 1'b1, "armed");
		wait_oct(5'd0, `TSC_TS1_CHAN);
		check(tx_slip_delay_o, e, "applied");
		gap = 0;
		while (tx_frame_bound_o !== 1'b1 && gap < 400) begin
			@(posedge clock_i);
			#1;
			gap++;
		end
		check(16'(gap), 16'(e), "offset");
		gap = 0;
		do begin
			@(posedge clock_i);
			#1;
			gap++;
		end while (tx_frame_bound_o !== 1'b1 && gap < 400);
		check(16'(gap), 16'(`TSC_FRAME_BITS), "period");
		reg_rd(`TSC_OFS_STATUS, r);
		check(r[1], 1'b0, "one shot");
		$display("t_delay done");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clock_i);
		arst_n_i <= 1'b1;
		t_reset;
		t_enables;
		t_yellow(1'b0);
		t_yellow(1'b1);
		t_oct(8'h80, 8'h20, 8'h00, 9'h000, 5'd0, 16'h1b00);
		t_oct(8'h80, 8'h20, 8'h55, 9'h000, 5'd0, 16'h5500);
		t_oct(8'h80, 8'h10, 8'h00, 9'h000, 5'd0, 16'h0200);
		t_oct(8'h80, 8'h40, 8'h00, 9'h03c, 5'd0, 16'h3c3c);
		t_oct(8'h80, 8'h04, 8'h00, 9'h05a, 5'd0, 16'h5a5a);
		t_oct(8'h80, 8'h01, 8'h00, 9'h096, 5'd0, 16'h9696);
		t_oct(8'h80, 8'h02, 8'ha5, 9'h000, 5'd0, 16'ha5a5);
		t_oct(8'h80, 8'h08, 8'hc3, 9'h000, 5'd0, 16'hc3c3);
		t_oct(8'h80, 8'h00, 8'h00, 9'h100, 5'd0, 16'h001b);
		t_oct(8'h80, 8'h80, 8'h00, 9'h100, 5'd0, 16'h0000);
		t_oct(8'ha8, 8'h00, 8'h00, 9'h000, 5'd6, 16'h0100);
		t_oct(8'ha8, 8'h00, 8'h00, 9'h000, 5'd5, 16'h0000);
		t_oct(8'h00, 8'h00, 8'h00, 9'h000, 5'd0, 16'h00ff);
		t_sig(1'b1, 8'h44, 8'h0f);
		t_sig(1'b0, 8'h44, 8'h0e);
		t_sig(1'b1, 8'h4c, 8'hf0);
		t_deb;
		// Host side writes nonzero delays only.
		t_delay(8'h05, 8'h05);
		t_delay(8'hff, `TSC_MAX_DELAY);
		test_done;
	end
endmodule
`default_nettype wire

// ### bench/tsc_line_model.sv
// Far-side partner: AMI line source and backplane pin resolution.
`timescale 1ns/100ps
`default_nettype none

module tsc_line_model import tsc_pkg::*; (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Octet to send, bit 8 asks for the zero code.
	input wire logic oct_stb_i,
	input wire logic [8:0] octet_i,
	// Backplane pin as driven by the block.
	input wire logic [7:0] data_out_i,
	input wire logic data_oe_i,
	// Line rails and resolved pin.
	output tsc_bipolar_t rails_o,
	output logic [7:0] data_pin_o
);
	logic pol_q;
	logic pol_d;
	logic [7:0] last_q;

	// Marks alternate; a zero octet may carry 000VB0VB with V as last mark.
	always_comb begin
		rails_o = '0;
		pol_d = pol_q;
		if (octet_i == 9'h100) begin
			rails_o.pos = pol_q ? 8'h11 : 8'h0a;
			rails_o.neg = pol_q ? 8'h0a : 8'h11;
		end else begin
			for (int i = 7; i >= 0; i--) begin
				if (octet_i[i]) begin
					rails_o.pos[i] = !pol_d;
					rails_o.neg[i] = pol_d;
					pol_d = !pol_d;
				end
			end
		end
	end

	// A released pin has no pull, so show the inverse of the last value.
	assign data_pin_o = data_oe_i ? data_out_i : ~last_q;

	// Polarity and last driven value.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pol_q <= 1'b0;
			last_q <= 8'h00;
		end else begin
			if (oct_stb_i)
				pol_q <= pol_d;
			if (data_oe_i)
				last_q <= data_out_i;
		end
	end
endmodule
`default_nettype wire

// ### hw/tsc_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
// ==========================================================
// Register offsets
`define TSC_OFS_SIG_CFG 8'h14
`define TSC_OFS_CODE_LOOP 8'h15
`define TSC_OFS_TX_DELAY 8'h17
`define TSC_OFS_STATUS 8'h1c
// ==========================================================
// Signalling configuration fields
`define TSC_SIG_DATA_OE 7
`define TSC_SIG_SIG_OE 6
`define TSC_SIG_RB_EN 5
`define TSC_SIG_DB_EN 4
`define TSC_SIG_UPPER 3
`define TSC_SIG_FILL_HI 2
`define TSC_SIG_FILL_LO 1
`define TSC_SIG_JAPAN 0
// ==========================================================
// Coding and loopback fields
`define TSC_CL_RX_DEC 7
`define TSC_CL_METAL 6
`define TSC_CL_TX_ENC 5
`define TSC_CL_STUFF 4
`define TSC_CL_DIGITAL 3
`define TSC_CL_REMOTE 2
`define TSC_CL_BACKPLANE 1
`define TSC_CL_PAYLOAD 0
// ==========================================================
// Status fields
`define TSC_ST_YEL_DET 0
`define TSC_ST_DLY_ARMED 1
// ==========================================================
// Reset values
`define TSC_SIG_CFG_RST 8'h00
`define TSC_CODE_LOOP_RST 8'h00
`define TSC_TX_DELAY_RST 8'h00
// ==========================================================
// Line patterns
`define TSC_B8ZS_SAME 8'h11
`define TSC_B8ZS_OPP 8'h0a
`define TSC_STUFF_BIT 8'h02
`define TSC_YEL_JAPAN 16'hffff
`define TSC_YEL_STD 16'hff00
// ==========================================================
// Framing and timing
`define TSC_RB_FRAME_A 5'd6
`define TSC_RB_FRAME_B 5'd12
`define TSC_RB_FRAME_C 5'd18
`define TSC_RB_FRAME_D 5'd24
`define TSC_TS1_CHAN 5'd0
`define TSC_FRAME_BITS 8'd193
`define TSC_MAX_DELAY 8'd192
`define TSC_DB_TICK_US 3000
`define TSC_CLK_KHZ 40000
`define TSC_DB_TICK_CYC (`TSC_DB_TICK_US * `TSC_CLK_KHZ / 1000)
`define TSC_DB_LAST_AGE 2'd2
`endif

// ### hw/tsc_pkg.sv
// Types shared by the T1 signalling, coding and loopback control block.
package tsc_pkg;
	// Bipolar octet: one bit per line slot on each rail.
	typedef struct packed {
		logic [7:0] pos;
		logic [7:0] neg;
	} tsc_bipolar_t;

	// Transmit slip delay request states.
	typedef enum logic [1:0] {
		TSC_DLY_IDLE = 2'b01,
		TSC_DLY_ARMED = 2'b10
	} tsc_dly_state_t;
endpackage

// ### hw/tsc_t1_ctrl.sv
// T1 signalling, line coding, loopback and slip delay control.
//
// Behaviour
// - Data output drives only when enabled.
// - Signalling output drives only when enabled.
// - Robbed bits go into bit 8 every sixth frame.
// - Debounce holds signalling stable six to nine ms.
// - Nibble select picks active nibble, tristates other.
// - D4 nibble: A, B, high filler, low filler.
// - ESF nibble: ABCD, filler bits ignored.
// - Japanese alarm uses sixteen ones pattern.
// - Receive decoder removes zero substitution codes.
// - Transmit all-zero octets get substitution code.
// - Metallic loop ties receive rails to transmit.
// - Forced stuffing sets bit 7 of zero channels.
// - Digital loop feeds transmit back into receive.
// - Remote loop returns received slots line side.
// - Backplane loop copies data input to output.
// - Payload loop returns received slots backplane side.
// - Each nonzero delay write arms one adjustment.
// - Delay counts from timeslot one channel strobe.
// - Delay shifts frame boundary, under one frame.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tsc_defines.svh"

module tsc_t1_ctrl import tsc_pkg::*; #(
	parameter int NCH = 24,
	parameter int DB_TICK_CYCLES = `TSC_DB_TICK_CYC
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Register port.
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Framing timebase from the framer core.
	input wire logic oct_stb_i,
	input wire logic [4:0] chan_i,
	input wire logic [4:0] frame_i,
	input wire logic esf_mode_i,
	input wire logic line_bit_en_i,
	// Backplane side.
	input wire logic [7:0] serial_data_in_i,
	input wire logic [7:0] sig_stream_in_i,
	output logic [7:0] serial_data_out_o,
	output logic serial_data_out_oe_o,
	output logic [7:0] sig_stream_out_o,
	output logic [7:0] sig_stream_out_oe_o,
	// Line side.
	input wire logic [7:0] rx_line_pos_i,
	input wire logic [7:0] rx_line_neg_i,
	input wire logic rx_fdl_bit_i,
	input wire logic rx_fdl_stb_i,
	output logic [7:0] tx_line_pos_o,
	output logic [7:0] tx_line_neg_o,
	output logic [15:0] tx_yellow_pattern_o,
	output logic rx_yellow_det_o,
	// Transmit slip buffer.
	output logic [7:0] tx_slip_delay_o,
	output logic tx_frame_bound_o
);
	localparam int DBW = $clog2(DB_TICK_CYCLES + 1);

	// ==========================================================
	// Register decode and fields
	logic [7:0] sig_cfg_q;
	logic [7:0] code_q;
	wire wr_sig_w = reg_wr_i && reg_addr_i == `TSC_OFS_SIG_CFG;
	wire wr_code_w = reg_wr_i && reg_addr_i == `TSC_OFS_CODE_LOOP;
	wire wr_dly_w = reg_wr_i && reg_addr_i == `TSC_OFS_TX_DELAY;
	wire data_oe_w = sig_cfg_q[`TSC_SIG_DATA_OE];
	wire sig_oe_w = sig_cfg_q[`TSC_SIG_SIG_OE];
	wire rb_en_w = sig_cfg_q[`TSC_SIG_RB_EN];
	wire db_en_w = sig_cfg_q[`TSC_SIG_DB_EN];
	wire upper_w = sig_cfg_q[`TSC_SIG_UPPER];
	wire [1:0] filler_w = {sig_cfg_q[`TSC_SIG_FILL_HI],
		sig_cfg_q[`TSC_SIG_FILL_LO]};
	wire japan_w = sig_cfg_q[`TSC_SIG_JAPAN];
	wire rx_dec_w = code_q[`TSC_CL_RX_DEC];
	wire metal_w = code_q[`TSC_CL_METAL];
	wire tx_enc_w = code_q[`TSC_CL_TX_ENC];
	wire stuff_w = code_q[`TSC_CL_STUFF];
	wire digital_w = code_q[`TSC_CL_DIGITAL];
	wire remote_w = code_q[`TSC_CL_REMOTE];
	wire bkpl_w = code_q[`TSC_CL_BACKPLANE];
	wire payload_w = code_q[`TSC_CL_PAYLOAD];

	// Control registers; software writes take effect the next cycle.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sig_cfg_q <= `TSC_SIG_CFG_RST;
			code_q <= `TSC_CODE_LOOP_RST;
		end else begin
			if (wr_sig_w) sig_cfg_q <= reg_wdata_i;
			if (wr_code_w) code_q <= reg_wdata_i;
		end
	end

	// ==========================================================
	// Line coding helpers
	// AMI marks alternate; lp is the polarity of the previous mark.
	function automatic tsc_bipolar_t ami_enc(input logic [7:0] d,
			input logic lp);
		tsc_bipolar_t r;
		logic p;
		r = '0;
		p = lp;
		for (int i = 7; i >= 0; i--) begin
			if (d[i]) begin
				p = ~p;
				r.pos[i] = p;
				r.neg[i] = ~p;
			end
		end
		return r;
	endfunction

	// Substitution 000VB0VB; it ends on the prior polarity.
	function automatic tsc_bipolar_t b8zs_code(input logic lp);
		tsc_bipolar_t r;
		r.pos = lp ? `TSC_B8ZS_SAME : `TSC_B8ZS_OPP;
		r.neg = lp ? `TSC_B8ZS_OPP : `TSC_B8ZS_SAME;
		return r;
	endfunction

	// ==========================================================
	// Receive path
	logic [7:0] tx_pos_q;
	logic [7:0] tx_neg_q;
	logic pol_q;
	tsc_bipolar_t rx_bip_w;
	// Digital loop
	// Receive decoder sees last transmitted octet instead of the line.
	assign rx_bip_w = digital_w ? {tx_pos_q, tx_neg_q}
		: {rx_line_pos_i, rx_line_neg_i};
	// Receive decoding
	// Either polarity of the substitution code decodes to zeros.
	wire rx_subst_w = rx_dec_w &&
		((rx_bip_w.pos == `TSC_B8ZS_SAME && rx_bip_w.neg == `TSC_B8ZS_OPP)
		|| (rx_bip_w.pos == `TSC_B8ZS_OPP && rx_bip_w.neg == `TSC_B8ZS_SAME));
	wire [7:0] rx_data_w = rx_subst_w ? 8'h00 : (rx_bip_w.pos | rx_bip_w.neg);

	// ==========================================================
	// Signalling frame slot
	// Frames 6, 12, 18, 24 carry A, B, C, D; D4 repeats A, B.
	wire rb_frame_w = frame_i == `TSC_RB_FRAME_A ||
		frame_i == `TSC_RB_FRAME_B || frame_i == `TSC_RB_FRAME_C ||
		frame_i == `TSC_RB_FRAME_D;
	wire [1:0] slot_w = {esf_mode_i && frame_i >= `TSC_RB_FRAME_C,
		frame_i == `TSC_RB_FRAME_B || frame_i == `TSC_RB_FRAME_D};
	wire [1:0] nib_idx_w = 2'd3 - slot_w;

	// ==========================================================
	// Transmit path
	// Input nibble choice
	wire [3:0] sig_in_nib_w = upper_w ? sig_stream_in_i[7:4]
		: sig_stream_in_i[3:0];
	wire rb_bit_w = sig_in_nib_w[nib_idx_w];
	wire [7:0] pay_w = payload_w ? rx_data_w : serial_data_in_i;
	wire rb_ins_w = rb_en_w && rb_frame_w;
	wire [7:0] rb_oct_w = rb_ins_w ? {pay_w[7:1], rb_bit_w} : pay_w;
	wire [7:0] stuff_oct_w = (stuff_w && rb_oct_w == 8'h00)
		? `TSC_STUFF_BIT : rb_oct_w;
	// Remote loop
	// Received slots are re-coded here, so line polarity stays legal.
	wire [7:0] enc_in_w = remote_w ? rx_data_w : stuff_oct_w;
	wire tx_subst_w = tx_enc_w && enc_in_w == 8'h00;
	tsc_bipolar_t tx_code_w;
	assign tx_code_w = tx_subst_w ? b8zs_code(pol_q)
		: ami_enc(enc_in_w, pol_q);
	// Metallic loop
	// Raw rails pass straight through; nothing re-codes them.
	tsc_bipolar_t tx_next_w;
	assign tx_next_w = metal_w ? {rx_line_pos_i, rx_line_neg_i} : tx_code_w;
	wire pol_d = (metal_w || tx_subst_w) ? pol_q : (pol_q ^ (^enc_in_w));
	wire [7:0] sdo_d = bkpl_w ? serial_data_in_i : rx_data_w;

	// Octet-rate outputs update on each timeslot strobe.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_pos_q <= 8'h00;
			tx_neg_q <= 8'h00;
			pol_q <= 1'b0;
			serial_data_out_o <= 8'h00;
		end else if (oct_stb_i) begin
			tx_pos_q <= tx_next_w.pos;
			tx_neg_q <= tx_next_w.neg;
			pol_q <= pol_d;
			serial_data_out_o <= sdo_d;
		end
	end
	assign tx_line_pos_o = tx_pos_q;
	assign tx_line_neg_o = tx_neg_q;

	// ==========================================================
	// Debounce timebase
	// One tick every 3 ms; three ticks after a change is 6 to 9 ms.
	logic [DBW-1:0] tick_cnt_q;
	logic tick_q;
	wire tick_end_w = tick_cnt_q == DBW'(DB_TICK_CYCLES - 1);
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_end_w ? '0 : tick_cnt_q + 1'b1;
			tick_q <= tick_end_w;
		end
	end

	// ==========================================================
	// Per-channel receive signalling
	wire [3:0] rep_w [0:NCH-1];
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [3:0] raw_q;
		logic [3:0] cand_q;
		logic [3:0] rep_q;
		logic [1:0] age_q;
		wire samp_w = oct_stb_i && chan_i == 5'(c) && rb_frame_w;
		wire commit_w = samp_w && (frame_i == `TSC_RB_FRAME_D ||
			(!esf_mode_i && frame_i == `TSC_RB_FRAME_B));
		wire [3:0] raw_d = samp_w ? ((raw_q & ~(4'h1 << nib_idx_w)) |
			({3'b000, rx_data_w[0]} << nib_idx_w)) : raw_q;
		wire change_w = commit_w && raw_d != cand_q;
		// Debounce
		// A new value restarts the age; it is reported at the third tick.
		always_ff @(posedge clock_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				raw_q <= 4'h0;
				cand_q <= 4'h0;
				rep_q <= 4'h0;
				age_q <= 2'd0;
			end else begin
				raw_q <= raw_d;
				if (change_w) begin
					cand_q <= raw_d;
					age_q <= 2'd0;
				end else if (tick_q && age_q != 2'd3) begin
					age_q <= age_q + 2'd1;
				end
				if (!db_en_w && commit_w) begin
					rep_q <= raw_d;
				end else if (db_en_w && !change_w && tick_q &&
						age_q == `TSC_DB_LAST_AGE) begin
					rep_q <= cand_q;
				end
			end
		end
		assign rep_w[c] = rep_q;
	end

	// ==========================================================
	// Signalling output stream
	wire [3:0] rep_sel_w = (chan_i < 5'(NCH)) ? rep_w[chan_i] : 4'h0;
	wire [3:0] nib_out_w = esf_mode_i ? rep_sel_w
		: {rep_sel_w[3:2], filler_w};
	wire [7:0] sig_out_d = upper_w ? {nib_out_w, 4'h0} : {4'h0, nib_out_w};
	wire [7:0] sig_oe_d = sig_oe_w ? (upper_w ? 8'hf0 : 8'h0f) : 8'h00;

	// Output enables follow the configuration one cycle later.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sig_stream_out_o <= 8'h00;
			sig_stream_out_oe_o <= 8'h00;
			serial_data_out_oe_o <= 1'b0;
		end else begin
			if (oct_stb_i) sig_stream_out_o <= sig_out_d;
			sig_stream_out_oe_o <= sig_oe_d;
			serial_data_out_oe_o <= data_oe_w;
		end
	end

	// ==========================================================
	// Yellow alarm pattern
	logic [15:0] fdl_sh_q;
	wire [15:0] yel_pat_w = japan_w ? `TSC_YEL_JAPAN : `TSC_YEL_STD;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fdl_sh_q <= 16'h0000;
			rx_yellow_det_o <= 1'b0;
			tx_yellow_pattern_o <= `TSC_YEL_STD;
		end else begin
			if (rx_fdl_stb_i) fdl_sh_q <= {fdl_sh_q[14:0], rx_fdl_bit_i};
			rx_yellow_det_o <= fdl_sh_q == yel_pat_w;
			tx_yellow_pattern_o <= yel_pat_w;
		end
	end

	// ==========================================================
	// Transmit slip delay
	tsc_dly_state_t dly_state_q;
	logic [7:0] dly_q;
	logic [7:0] bit_cnt_q;
	// Zero writes are dropped; longer ones clamp below a frame.
	wire dly_take_w = wr_dly_w && reg_wdata_i != 8'h00;
	wire [7:0] dly_wval_w = (reg_wdata_i > `TSC_MAX_DELAY) ? `TSC_MAX_DELAY
		: reg_wdata_i;
	// Applied at the channel carrying timeslot one.
	wire dly_apply_w = dly_state_q == TSC_DLY_ARMED && oct_stb_i &&
		chan_i == `TSC_TS1_CHAN;
	wire bit_wrap_w = bit_cnt_q == `TSC_MAX_DELAY;

	// One-shot request; a write in the apply cycle still applies the old delay and stays armed.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dly_state_q <= TSC_DLY_IDLE;
			dly_q <= `TSC_TX_DELAY_RST;
		end else begin
			case (dly_state_q)
				TSC_DLY_IDLE: begin
					if (dly_take_w) dly_state_q <= TSC_DLY_ARMED;
				end
				TSC_DLY_ARMED: begin
					if (dly_apply_w && !dly_take_w) dly_state_q <= TSC_DLY_IDLE;
				end
				default: dly_state_q <= TSC_DLY_IDLE;
			endcase
			if (dly_take_w) dly_q <= dly_wval_w;
		end
	end

	// Frame boundary moves so it falls dly bit times later.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bit_cnt_q <= 8'h00;
			tx_frame_bound_o <= 1'b0;
			tx_slip_delay_o <= `TSC_TX_DELAY_RST;
		end else begin
			if (dly_apply_w) begin
				bit_cnt_q <= `TSC_FRAME_BITS - dly_q;
				tx_slip_delay_o <= dly_q;
			end else if (line_bit_en_i) begin
				bit_cnt_q <= bit_wrap_w ? 8'h00 : bit_cnt_q + 8'h01;
			end
			tx_frame_bound_o <= line_bit_en_i && bit_wrap_w && !dly_apply_w;
		end
	end

	// ==========================================================
	// Read port
	wire [7:0] status_w = {6'h00, dly_state_q == TSC_DLY_ARMED,
		rx_yellow_det_o};
	wire [7:0] rd_mux_w =
		(reg_addr_i == `TSC_OFS_SIG_CFG) ? sig_cfg_q :
		(reg_addr_i == `TSC_OFS_CODE_LOOP) ? code_q :
		(reg_addr_i == `TSC_OFS_STATUS) ? status_w : 8'h00;
	// Data stand only in the cycle after the read strobe.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) reg_rdata_o <= 8'h00;
		else reg_rdata_o <= reg_rd_i ? rd_mux_w : 8'h00;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_dly_write;
		reg_wr_i && reg_addr_i == `TSC_OFS_TX_DELAY && reg_wdata_i != 8'h00;
	endsequence
	sequence s_ts1_apply;
		dly_state_q == TSC_DLY_ARMED && oct_stb_i &&
			chan_i == `TSC_TS1_CHAN && !wr_dly_w;
	endsequence

	a_data_oe_follow: assert property (
		wr_sig_w |-> ##2 serial_data_out_oe_o == $past(reg_wdata_i[7], 2))
		else $error("data output enable does not follow its bit");
	a_sig_nibble_oe: assert property (
		wr_sig_w ##2 !wr_sig_w |-> sig_stream_out_oe_o ==
		($past(reg_wdata_i[6], 2) ? ($past(reg_wdata_i[3], 2)
		? 8'hf0 : 8'h0f) : 8'h00))
		else $error("signalling nibble enables wrong");
	a_robbed_bit_ins: assert property (
		oct_stb_i && rb_ins_w && rb_bit_w && !metal_w && !remote_w
		|=> tx_line_pos_o[0] || tx_line_neg_o[0])
		else $error("robbed signalling bit missing");
	a_debounce_hold: assert property (
		db_en_w && $past(db_en_w) && $changed(rep_w[0]) |-> $past(tick_q))
		else $error("debounced signalling changed off a tick");
	a_d4_filler_bits: assert property (
		oct_stb_i && !esf_mode_i && !upper_w
		|=> sig_stream_out_o[1:0] == $past(filler_w))
		else $error("filler bits not in low nibble slots");
	a_yellow_japan: assert property (
		japan_w && $past(japan_w) && rx_yellow_det_o
		|-> $past(fdl_sh_q) == 16'hffff)
		else $error("yellow detected without sixteen ones");
	a_rx_subst_dec: assert property (
		oct_stb_i && rx_subst_w && !bkpl_w |=> serial_data_out_o == 8'h00)
		else $error("substitution code not decoded");
	a_tx_subst_enc: assert property (
		oct_stb_i && tx_subst_w && !metal_w
		|=> (tx_line_pos_o | tx_line_neg_o) == 8'h1b &&
		tx_line_pos_o[4] == $past(pol_q))
		else $error("zero octet not substituted");
	a_metal_loop: assert property (
		oct_stb_i && metal_w |=> tx_line_pos_o == $past(rx_line_pos_i) &&
		tx_line_neg_o == $past(rx_line_neg_i))
		else $error("metallic loop rails differ");
	a_forced_stuff: assert property (
		oct_stb_i && stuff_w && !remote_w && !metal_w && rb_oct_w == 8'h00
		|=> tx_line_pos_o == 8'h02 || tx_line_neg_o == 8'h02)
		else $error("forced stuffing bit missing");
	a_bkpl_loop: assert property (
		oct_stb_i && bkpl_w |=> serial_data_out_o == $past(serial_data_in_i))
		else $error("backplane loop data differ");
	a_dly_arm: assert property (
		s_dly_write |=> dly_state_q == TSC_DLY_ARMED)
		else $error("delay write did not arm");
	a_dly_apply: assert property (
		s_ts1_apply |=> dly_state_q == TSC_DLY_IDLE &&
		bit_cnt_q == `TSC_FRAME_BITS - $past(dly_q))
		else $error("delay not applied once at timeslot one");
	a_bound_range: assert property (
		bit_cnt_q <= `TSC_MAX_DELAY && tx_slip_delay_o <= `TSC_MAX_DELAY)
		else $error("frame boundary beyond one frame");
endmodule

`default_nettype wire
